/* icf_pkg.sv */
package icf_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_MAIN = 8'h00;
    localparam logic [7:0] ADDR_EDGE = 8'h04;
    localparam logic [7:0] ADDR_EXT = 8'h08;
    localparam logic [7:0] ADDR_PRF1 = 8'h0c;
    localparam logic [7:0] ADDR_RESET_CONTROL_REG = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    localparam logic [7:0] ADDR_SERBUF = 8'h18;
    localparam logic [7:0] ADDR_PORT_B_PINS = 8'h1c;
    // main control fields
    localparam int GH_BIT = 7;
    localparam int PL_BIT = 6;
    localparam int T0E_BIT = 5;
    localparam int I0E_BIT = 4;
    localparam int PCE_BIT = 3;
    localparam int T0F_BIT = 2;
    localparam int I0F_BIT = 1;
    localparam int PCF_BIT = 0;
    // edge / priority control fields
    localparam int PUD_BIT = 7;
    localparam int EDG0_BIT = 6;
    localparam int EDG3_BIT = 3;
    localparam int T0P_BIT = 2;
    localparam int I3P_BIT = 1;
    localparam int PCP_BIT = 0;
    // external pin control fields
    localparam int I2P_BIT = 7;
    localparam int I1P_BIT = 6;
    localparam int I1E_BIT = 3;
    localparam int I1F_BIT = 0;
    // peripheral flag fields
    localparam int RXF_BIT = 5;
    localparam int TXF_BIT = 4;
    localparam int SSF_BIT = 3;
    localparam int T2F_BIT = 1;
    localparam int T1F_BIT = 0;
    localparam logic [7:0] PRF1_IMPL = 8'h3b;
    localparam logic [7:0] PRF1_SWCLR = 8'h0b;
    localparam int PMODE_BIT = 7;
    // reset values
    localparam logic [7:0] MAIN_RST = 8'h00;
    localparam logic [7:0] EDGE_RST = 8'hff;
    localparam logic [7:0] EXT_RST = 8'hc0;
    localparam logic [7:0] PRF1_RST = 8'h00;
    // vectors
    localparam logic [15:0] VEC_HIGH = 16'h0008;
    localparam logic [15:0] VEC_LOW = 16'h0018;
    // mismatch hold: one hclk cycle after a port read
    localparam int MISMATCH_HOLD = 1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic timer_zero_ovf;
        logic [3:0] ext_pin;
        logic sync_serial_done;
        logic timer_two_match;
        logic timer_one_ovf;
        logic serial_rx_full;
        logic serial_tx_empty;
        logic peri_req;
        logic peri_prio;
    } icf_events_t;

    typedef struct packed {
        logic req_high;
        logic req_low;
        logic [15:0] vector;
    } icf_core_req_t;

    typedef enum logic [1:0] {
        ICF_IDLE = 2'b00,
        ICF_LOW = 2'b01,
        ICF_HIGH = 2'b10
    } icf_svc_t;
endpackage

/* icf_interrupt_control.sv */
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - flags set on their events regardless of any enable bits.
// - priority off: main bit 7 is the global enable for all sources.
// - priority on: main bit 7 enables high-priority sources, clear blocks all.
// - priority off: main bit 6 gates all peripheral sources.
// - priority on: main bit 6 gates all low-priority sources.
// - timer-zero overflow sets main bit 2, enabled by bit 5, software clears.
// - ext pin 0 selected edge sets main bit 1, enabled by bit 4.
// - any change on port-B pins 7..4 sets main bit 0, enabled by bit 3.
// - mismatch keeps setting flag until port read plus one more cycle; here setting stops at the read and the next cycle is masked.
// - edge register bit 7 set disables all port-B pull-ups.
// - edge register bits 6..3 pick edge of ext pins 0..3, 1 rising.
// - edge register bits 2,1,0 give priority of timer0, pin3, port change.
// - ext register bits 7,6 give priority of ext pins 2 and 1.
// - ext register holds pin 3..1 enables at 5..3, flags at 2..0.
// - peripheral bit 5 shows receive buffer full, cleared by buffer read.
// - peripheral bit 4 shows transmit buffer empty, cleared by buffer write.
// - peripheral bit 3 sets on sync serial completion, software clears.
// - peripheral bit 1 sets on timer two match, software clears.
// - peripheral bit 0 sets on timer one overflow, software clears.
// - peripheral bits 7 and 2 read zero and ignore writes.
// - priority mode bit is reset-control bit 7, default off, one vector.
// - qualified request vectors at once, high 0008h, low 0018h; here core_req is registered, one hclk cycle later.
// - accepting clears governing global enable, return sets it again.
module icf_interrupt_control (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // event sources, same clock
    input wire icf_pkg::icf_events_t events,
    // pins
    input wire logic [3:0] ext_pins,
    input wire logic [3:0] port_b_pins,
    input wire logic [3:0] port_b_latch,
    // core side
    input wire logic isr_accept,
    input wire logic return_from_isr,
    output icf_pkg::icf_core_req_t core_req,
    output logic [3:0] pullup_en
);
    logic [7:0] main_interrupt_control;
    logic [7:0] edge_priority_control;
    logic [7:0] external_pin_interrupt_control;
    logic [7:0] peripheral_request_flags_one;
    logic priority_mode_enable;
    logic [3:0] ext_s1, ext_s2, ext_d;
    logic [3:0] pb_s1, pb_s2, pb_ref;
    logic mis_hold_reg;
    logic ap_valid, ap_write;
    logic [7:0] ap_addr;
    logic wr_strobe, rd_strobe;
    logic [7:0] wdat;
    logic [3:0] edge_hit;
    logic port_mismatch;
    logic [1:0] svc_reg;
    icf_pkg::icf_svc_t svc_state;
    logic hi_pend, lo_pend;
    logic take_high, take_low;

    function automatic logic wr_to(input logic [7:0] a);
        wr_to = wr_strobe && (ap_addr == a);
    endfunction

    // address phase capture; the slave always answers in zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
        end else if (hready) begin
            ap_valid <= hsel && (htrans == icf_pkg::HTRANS_NONSEQ);
            ap_write <= hwrite;
            ap_addr <= haddr;
        end
    end

    assign wr_strobe = ap_valid && ap_write;
    assign rd_strobe = hsel && hready && !hwrite &&
        (htrans == icf_pkg::HTRANS_NONSEQ);
    assign wdat = hwdata[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // pin synchronisers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_s1 <= 4'h0;
            ext_s2 <= 4'h0;
            ext_d <= 4'h0;
            pb_s1 <= 4'h0;
            pb_s2 <= 4'h0;
        end else begin
            ext_s1 <= ext_pins;
            ext_s2 <= ext_s1;
            ext_d <= ext_s2;
            pb_s1 <= port_b_pins;
            pb_s2 <= pb_s1;
        end
    end

    // edge select per pin: 1 rising, 0 falling
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            edge_hit[i] = edge_priority_control[icf_pkg::EDG0_BIT - i]
                ? (ext_s2[i] && !ext_d[i])
                : (!ext_s2[i] && ext_d[i]);
        end
    end

    // port reference latched by a port read; mismatch sets the flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pb_ref <= 4'h0;
            mis_hold_reg <= 1'b0;
        end else begin
            mis_hold_reg <= 1'b0;
            if (rd_strobe && haddr == icf_pkg::ADDR_PORT_B_PINS) begin
                pb_ref <= pb_s2;
                mis_hold_reg <= 1'(icf_pkg::MISMATCH_HOLD);
            end
        end
    end

    assign port_mismatch = (pb_s2 != pb_ref) && !mis_hold_reg;

    // main control register: flag set beats clear, accept clear beats enable set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_interrupt_control <= icf_pkg::MAIN_RST;
        end else begin
            if (wr_to(icf_pkg::ADDR_MAIN)) begin
                main_interrupt_control <= wdat;
            end
            if (take_high) begin
                main_interrupt_control[icf_pkg::GH_BIT] <= 1'b0;
            end else if (take_low) begin
                main_interrupt_control[icf_pkg::PL_BIT] <= 1'b0;
            end else if (return_from_isr) begin
                if (!priority_mode_enable || svc_state == icf_pkg::ICF_HIGH)
                    main_interrupt_control[icf_pkg::GH_BIT] <= 1'b1;
                else
                    main_interrupt_control[icf_pkg::PL_BIT] <= 1'b1;
            end
            if (events.timer_zero_ovf)
                main_interrupt_control[icf_pkg::T0F_BIT] <= 1'b1;
            if (edge_hit[0])
                main_interrupt_control[icf_pkg::I0F_BIT] <= 1'b1;
            if (port_mismatch)
                main_interrupt_control[icf_pkg::PCF_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edge_priority_control <= icf_pkg::EDGE_RST;
        end else if (wr_to(icf_pkg::ADDR_EDGE)) begin
            edge_priority_control <= wdat;
        end
    end

    // ext pin register: pins 1..3 flags in bits 0..2
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            external_pin_interrupt_control <= icf_pkg::EXT_RST;
        end else begin
            if (wr_to(icf_pkg::ADDR_EXT))
                external_pin_interrupt_control <= wdat;
            for (int i = 1; i < 4; i++) begin
                if (edge_hit[i])
                    external_pin_interrupt_control[icf_pkg::I1F_BIT + i - 1]
                        <= 1'b1;
            end
        end
    end

    // peripheral flags; rx/tx bits track buffer state, read-only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            peripheral_request_flags_one <= icf_pkg::PRF1_RST;
        end else begin
            if (wr_to(icf_pkg::ADDR_PRF1))
                peripheral_request_flags_one <=
                    (peripheral_request_flags_one & ~icf_pkg::PRF1_SWCLR) |
                    (wdat & icf_pkg::PRF1_SWCLR);
            peripheral_request_flags_one[icf_pkg::RXF_BIT] <=
                events.serial_rx_full;
            peripheral_request_flags_one[icf_pkg::TXF_BIT] <=
                events.serial_tx_empty;
            if (events.sync_serial_done)
                peripheral_request_flags_one[icf_pkg::SSF_BIT] <= 1'b1;
            if (events.timer_two_match)
                peripheral_request_flags_one[icf_pkg::T2F_BIT] <= 1'b1;
            if (events.timer_one_ovf)
                peripheral_request_flags_one[icf_pkg::T1F_BIT] <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            priority_mode_enable <= 1'b0;
        end else if (wr_to(icf_pkg::ADDR_RESET_CONTROL_REG)) begin
            priority_mode_enable <= wdat[icf_pkg::PMODE_BIT];
        end
    end

    // source qualification
    always_comb begin
        logic [7:0] m, e, x, p;
        logic [6:0] act, prio;
        logic any_core_hi, any_core_lo, peri_act;
        act = 7'h00;
        prio = 7'h00;
        peri_act = 1'b0;
        any_core_hi = 1'b0;
        any_core_lo = 1'b0;
        m = main_interrupt_control;
        e = edge_priority_control;
        x = external_pin_interrupt_control;
        p = peripheral_request_flags_one;
        act[0] = m[icf_pkg::T0F_BIT] && m[icf_pkg::T0E_BIT];
        act[1] = m[icf_pkg::I0F_BIT] && m[icf_pkg::I0E_BIT];
        act[2] = m[icf_pkg::PCF_BIT] && m[icf_pkg::PCE_BIT];
        act[3] = x[icf_pkg::I1F_BIT] && x[icf_pkg::I1E_BIT];
        act[4] = x[icf_pkg::I1F_BIT + 1] && x[icf_pkg::I1E_BIT + 1];
        act[5] = x[icf_pkg::I1F_BIT + 2] && x[icf_pkg::I1E_BIT + 2];
        act[6] = events.peri_req;
        prio[0] = e[icf_pkg::T0P_BIT];
        prio[1] = 1'b1;
        prio[2] = e[icf_pkg::PCP_BIT];
        prio[3] = x[icf_pkg::I1P_BIT];
        prio[4] = x[icf_pkg::I2P_BIT];
        prio[5] = e[icf_pkg::I3P_BIT];
        prio[6] = events.peri_prio;
        peri_act = act[6] && p[7] == 1'b0;
        any_core_hi = |(act[5:0] & prio[5:0]) || (peri_act && prio[6]);
        any_core_lo = |(act[5:0] & ~prio[5:0]) || (peri_act && !prio[6]);
        if (!priority_mode_enable) begin
            hi_pend = m[icf_pkg::GH_BIT] &&
                (|act[5:0] || (peri_act && m[icf_pkg::PL_BIT]));
            lo_pend = 1'b0;
        end else begin
            hi_pend = m[icf_pkg::GH_BIT] && any_core_hi;
            lo_pend = m[icf_pkg::GH_BIT] && m[icf_pkg::PL_BIT] &&
                any_core_lo;
        end
    end

    assign svc_state = icf_pkg::icf_svc_t'(svc_reg);
    assign take_high = isr_accept && hi_pend &&
        svc_state != icf_pkg::ICF_HIGH;
    assign take_low = isr_accept && !hi_pend && lo_pend &&
        svc_state == icf_pkg::ICF_IDLE;

    // service level tracking; a high service returns to the interrupted low
    logic low_nested_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            svc_reg <= icf_pkg::ICF_IDLE;
            low_nested_reg <= 1'b0;
        end else if (take_high) begin
            low_nested_reg <= svc_state == icf_pkg::ICF_LOW;
            svc_reg <= icf_pkg::ICF_HIGH;
        end else if (take_low) begin
            svc_reg <= icf_pkg::ICF_LOW;
        end else if (return_from_isr) begin
            unique case (svc_state)
                icf_pkg::ICF_HIGH: begin
                    svc_reg <= low_nested_reg ? icf_pkg::ICF_LOW
                                              : icf_pkg::ICF_IDLE;
                    low_nested_reg <= 1'b0;
                end
                icf_pkg::ICF_LOW: svc_reg <= icf_pkg::ICF_IDLE;
                default: svc_reg <= icf_pkg::ICF_IDLE;
            endcase
        end
    end

    // core requests, registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_req <= '0;
        end else begin
            core_req.req_high <= hi_pend && svc_state != icf_pkg::ICF_HIGH;
            core_req.req_low <= lo_pend && svc_state == icf_pkg::ICF_IDLE;
            core_req.vector <= (hi_pend || !priority_mode_enable)
                ? icf_pkg::VEC_HIGH : icf_pkg::VEC_LOW;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pullup_en <= 4'h0;
        end else begin
            pullup_en <= edge_priority_control[icf_pkg::PUD_BIT]
                ? 4'h0 : port_b_latch;
        end
    end

    // read data, registered in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_strobe) begin
            unique case (haddr)
                icf_pkg::ADDR_MAIN: hrdata <= {24'h0, main_interrupt_control};
                icf_pkg::ADDR_EDGE: hrdata <= {24'h0, edge_priority_control};
                icf_pkg::ADDR_EXT:
                    hrdata <= {24'h0, external_pin_interrupt_control};
                icf_pkg::ADDR_PRF1: hrdata <= {24'h0,
                    peripheral_request_flags_one & icf_pkg::PRF1_IMPL};
                icf_pkg::ADDR_RESET_CONTROL_REG:
                    hrdata <= {24'h0, priority_mode_enable, 7'h00};
                icf_pkg::ADDR_STAT: hrdata <= {28'h0, 2'h0, svc_reg};
                icf_pkg::ADDR_PORT_B_PINS: hrdata <= {28'h0, pb_s2};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // icf_interrupt_control
`default_nettype wire

/* icf_interrupt_control_props.sv */
`timescale 1ns/1ps
`default_nettype none
module icf_props (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // pins and core side
    input wire logic [3:0] port_b_latch,
    input wire logic isr_accept,
    input wire icf_pkg::icf_core_req_t core_req,
    input wire logic [3:0] pullup_en
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_take;
    assign rd_take = hsel && hready && !hwrite
        && htrans == icf_pkg::HTRANS_NONSEQ;
    sequence s_take_high;
        isr_accept && core_req.req_high;
    endsequence
    sequence s_drop_high;
        ##[1:2] !core_req.req_high;
    endsequence
    property p_okay;
        hreadyout && !hresp;
    endproperty
    property p_upper;
        hrdata[31:8] == 24'h0;
    endproperty
    property p_hold;
        !$past(rd_take) |-> $stable(hrdata);
    endproperty
    property p_pullup;
        (pullup_en & ~$past(port_b_latch)) == 4'h0;
    endproperty
    property p_vec_high;
        core_req.req_high |-> core_req.vector == icf_pkg::VEC_HIGH;
    endproperty
    property p_vec_low;
        core_req.req_low && !core_req.req_high
            |-> core_req.vector == icf_pkg::VEC_LOW;
    endproperty
    property p_accept;
        s_take_high |-> s_drop_high;
    endproperty
    property p_rst;
        $rose(hresetn) |-> !core_req.req_high && !core_req.req_low;
    endproperty
    a_okay: assert property (p_okay) else $error("bus answer not okay");
    a_upper: assert property (p_upper) else $error("upper read bits set");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_pullup: assert property (p_pullup)
        else $error("pull-up without latch");
    a_vec_high: assert property (p_vec_high)
        else $error("high vector wrong");
    a_vec_low: assert property (p_vec_low)
        else $error("low vector wrong");
    a_accept: assert property (p_accept)
        else $error("request stays after accept");
    a_rst: assert property (p_rst)
        else $error("request out of reset");
endmodule // icf_props
`default_nettype wire

/* icf_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module icf_core_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bench control
    input wire logic ack_en,
    input wire logic [3:0] ack_dly,
    // request side
    input wire icf_pkg::icf_core_req_t core_req,
    output logic isr_accept,
    output logic return_from_isr,
    output logic [15:0] last_vector
);
    logic [3:0] wait_cnt;
    initial return_from_isr = 1'b0;
    // a busy core takes a pending request only after ack_dly cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            isr_accept <= 1'b0;
            wait_cnt <= 4'h0;
            last_vector <= 16'h0;
        end else if (ack_en && !isr_accept
                && (core_req.req_high || core_req.req_low)) begin
            isr_accept <= (wait_cnt == ack_dly);
            wait_cnt <= (wait_cnt == ack_dly) ? 4'h0 : wait_cnt + 4'h1;
            if (wait_cnt == ack_dly) begin
                last_vector <= core_req.vector;
            end
        end else begin
            isr_accept <= 1'b0;
            wait_cnt <= 4'h0;
        end
    end
    task automatic ret();
        @(posedge hclk);
        return_from_isr <= 1'b1;
        @(posedge hclk);
        return_from_isr <= 1'b0;
    endtask
endmodule // icf_core_model
`default_nettype wire

/* test_interrupt_control_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_control_flags;
    localparam logic [7:0] A_MAIN = icf_pkg::ADDR_MAIN;
    localparam logic [7:0] A_EDGE = icf_pkg::ADDR_EDGE;
    localparam logic [7:0] A_EXT = icf_pkg::ADDR_EXT;
    localparam logic [7:0] A_PRF = icf_pkg::ADDR_PRF1;
    localparam logic [7:0] A_RESET_CONTROL_REG = icf_pkg::ADDR_RESET_CONTROL_REG;
    localparam logic [7:0] A_PORT = icf_pkg::ADDR_PORT_B_PINS;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic hresp;
    icf_pkg::icf_events_t events = '0;
    logic [3:0] ext_pins = 4'h0;
    logic [3:0] port_b_pins = 4'h0;
    logic [3:0] port_b_latch = 4'h0;
    logic ack_en = 1'b0;
    logic [3:0] ack_dly = 4'h2;
    wire logic isr_accept;
    wire logic return_from_isr;
    wire icf_pkg::icf_core_req_t core_req;
    wire logic [3:0] pullup_en;
    wire logic [15:0] last_vector;
    logic [31:0] v;
    int fail_count = 0;
    int tests_run = 0;
    always #5 hclk = ~hclk;
    icf_interrupt_control u_icf_interrupt_control (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .events(events), .ext_pins(ext_pins), .port_b_pins(port_b_pins),
        .port_b_latch(port_b_latch), .isr_accept(isr_accept),
        .return_from_isr(return_from_isr), .core_req(core_req),
        .pullup_en(pullup_en));
    icf_core_model u_core (.hclk(hclk), .hresetn(hresetn), .ack_en(ack_en),
        .ack_dly(ack_dly), .core_req(core_req), .isr_accept(isr_accept),
        .return_from_isr(return_from_isr), .last_vector(last_vector));
    task automatic check(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic bus(input logic [7:0] a, input logic w,
            input logic [7:0] d);
        haddr <= a;
        hwrite <= w;
        hsel <= 1'b1;
        htrans <= icf_pkg::HTRANS_NONSEQ;
        do @(posedge hclk);
        while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk);
        while (hreadyout !== 1'b1);
        v = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic chk_rd(input string name, input logic [7:0] a,
            input logic [31:0] exp);
        bus(a, 1'b0, 8'h00);
        check(name, v, exp);
    endtask
    // event bits: 800 timer zero, 070 sync serial, timer two, timer one
    task automatic pulse(input icf_pkg::icf_events_t e);
        events <= events | e;
        @(posedge hclk);
        events <= events & ~e;
        @(posedge hclk);
    endtask
    task automatic t_reset();
        chk_rd("main", A_MAIN, {24'h0, icf_pkg::MAIN_RST});
        chk_rd("edge", A_EDGE, {24'h0, icf_pkg::EDGE_RST});
        chk_rd("ext", A_EXT, {24'h0, icf_pkg::EXT_RST});
        chk_rd("prf1", A_PRF, {24'h0, icf_pkg::PRF1_RST});
        chk_rd("reset_control_reg", A_RESET_CONTROL_REG, 32'h0);
        chk_rd("unmapped", 8'h18, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_timer();
        pulse(12'h800);
        chk_rd("t0 flag", A_MAIN, 32'h04);
        check("t0 masked", core_req.req_high, 1'b0);
        wr(A_MAIN, 8'ha4);
        tick(3);
        check("t0 req", core_req, {2'b10, icf_pkg::VEC_HIGH});
        ack_en <= 1'b1;
        tick(8);
        ack_en <= 1'b0;
        check("t0 vec", last_vector, icf_pkg::VEC_HIGH);
        chk_rd("gie off", A_MAIN, 32'h24);
        u_core.ret();
        tick(2);
        chk_rd("gie on", A_MAIN, 32'ha4);
        wr(A_MAIN, 8'ha0);
        chk_rd("t0 clr", A_MAIN, 32'ha0);
        check("t0 req off", core_req.req_high, 1'b0);
        wr(A_MAIN, 8'h00);
        $display("test timer done");
    endtask
    task automatic t_ext();
        ext_pins[0] <= 1'b1;
        tick(4);
        chk_rd("rise", A_MAIN, 32'h02);
        wr(A_MAIN, 8'h00);
        wr(A_EDGE, 8'hbf);
        ext_pins[0] <= 1'b0;
        tick(4);
        chk_rd("fall", A_MAIN, 32'h02);
        wr(A_MAIN, 8'h00);
        ext_pins[0] <= 1'b1;
        tick(4);
        chk_rd("no rise", A_MAIN, 32'h00);
        wr(A_EDGE, 8'hff);
        ext_pins <= 4'he;
        tick(4);
        chk_rd("pins", A_EXT, 32'hc7);
        chk_rd("no fall", A_MAIN, 32'h00);
        wr(A_EXT, 8'hc0);
        ext_pins <= 4'h0;
        tick(4);
        chk_rd("pins clr", A_EXT, 32'hc0);
        $display("test ext done");
    endtask
    task automatic t_port();
        chk_rd("port", A_PORT, 32'h0);
        tick(2);
        wr(A_MAIN, 8'h88);
        port_b_pins <= 4'h5;
        tick(5);
        check("pc req", core_req.req_high, 1'b1);
        wr(A_MAIN, 8'h80);
        tick(1);
        chk_rd("pc hold", A_MAIN, 32'h81);
        chk_rd("port new", A_PORT, 32'h5);
        tick(2);
        wr(A_MAIN, 8'h00);
        chk_rd("pc clr", A_MAIN, 32'h00);
        port_b_latch <= 4'ha;
        wr(A_EDGE, 8'h7f);
        tick(2);
        check("pullup", pullup_en, 4'ha);
        wr(A_EDGE, 8'hff);
        tick(2);
        check("no pullup", pullup_en, 4'h0);
        $display("test port done");
    endtask
    task automatic t_periph();
        pulse(12'h070);
        chk_rd("periph", A_PRF, 32'h0b);
        events.serial_rx_full <= 1'b1;
        tick(2);
        wr(A_PRF, 8'hff);
        chk_rd("rx full", A_PRF, 32'h2b);
        events.serial_rx_full <= 1'b0;
        events.serial_tx_empty <= 1'b1;
        wr(A_PRF, 8'h00);
        chk_rd("tx empty", A_PRF, 32'h10);
        events.serial_tx_empty <= 1'b0;
        wr(A_MAIN, 8'h40);
        events.peri_req <= 1'b1;
        tick(3);
        check("pe only", core_req.req_high, 1'b0);
        wr(A_MAIN, 8'hc0);
        tick(3);
        check("pe req", core_req.req_high, 1'b1);
        wr(A_MAIN, 8'h80);
        tick(3);
        check("pe off", core_req.req_high, 1'b0);
        events.peri_req <= 1'b0;
        $display("test periph done");
    endtask
    task automatic t_prio();
        wr(A_RESET_CONTROL_REG, 8'h80);
        chk_rd("reset_control_reg on", A_RESET_CONTROL_REG, 32'h80);
        wr(A_EDGE, 8'hfb);
        wr(A_MAIN, 8'h60);
        pulse(12'h800);
        tick(2);
        check("gh clear", core_req, {2'b00, icf_pkg::VEC_LOW});
        wr(A_MAIN, 8'he4);
        tick(3);
        check("low req", core_req, {2'b01, icf_pkg::VEC_LOW});
        ack_dly <= 4'h5;
        ack_en <= 1'b1;
        tick(10);
        check("low vec", last_vector, icf_pkg::VEC_LOW);
        chk_rd("gl off", A_MAIN, 32'ha4);
        wr(A_MAIN, 8'hb4);
        ext_pins[0] <= 1'b1;
        tick(14);
        ack_en <= 1'b0;
        check("preempt", last_vector, icf_pkg::VEC_HIGH);
        chk_rd("gh off", A_MAIN, 32'h36);
        $display("test prio done");
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100us;
        fail_count++;
        stop_test();
    end
    initial begin
        tick(10);
        hresetn <= 1'b1;
        tick(1);
        t_reset();
        t_timer();
        t_ext();
        t_port();
        t_periph();
        t_prio();
        stop_test();
    end
endmodule // test_interrupt_control_flags
bind icf_interrupt_control icf_props u_icf_props (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .port_b_latch(port_b_latch), .isr_accept(isr_accept),
    .core_req(core_req), .pullup_en(pullup_en));
`default_nettype wire
